// >>> lcf_pkg.sv
// ----------------------------------------
// Framer constants
// ----------------------------------------
package lcf_pkg;
	// Register indices (byte address = index * 4)
	localparam logic [8:0] IDX_T1_CRIT = 9'h014;
	localparam logic [8:0] IDX_OOS_A = 9'h054;
	localparam logic [8:0] IDX_OOS_B = 9'h055;
	localparam logic [8:0] IDX_RX_LC_A = 9'h064;
	localparam logic [8:0] IDX_RX_LC_B = 9'h065;
	localparam logic [8:0] IDX_RX_LC_C = 9'h066;
	localparam logic [8:0] IDX_RX_MASTER = 9'h080;
	localparam logic [8:0] IDX_RX_CTL1 = 9'h081;
	localparam logic [8:0] IDX_E1_LOS = 9'h082;
	localparam logic [8:0] IDX_RX_LATCHED_STATUS_ONE = 9'h090;
	localparam logic [8:0] IDX_RX_LATCHED_STATUS_TWO = 9'h091;
	localparam logic [8:0] IDX_RX_LATCHED_STATUS_FOUR = 9'h093;
	localparam logic [8:0] IDX_RX_IRQ_MASK_ONE = 9'h0a0;
	localparam logic [8:0] IDX_RX_IRQ_MASK_TWO = 9'h0a1;
	localparam logic [8:0] IDX_RX_IRQ_MASK_FOUR = 9'h0a3;
	localparam logic [8:0] IDX_TX_LC_A = 9'h164;
	localparam logic [8:0] IDX_TX_LC_B = 9'h165;
	localparam logic [8:0] IDX_TX_LC_C = 9'h166;
	localparam logic [8:0] IDX_TX_MASTER = 9'h180;
	localparam logic [8:0] IDX_TX_CTL1 = 9'h181;
	localparam logic [8:0] IDX_TX_CTL2 = 9'h182;
	localparam logic [8:0] IDX_TX_CTL3 = 9'h183;
	localparam logic [8:0] IDX_TX_E1_OH = 9'h1c0;
	// Field positions
	localparam int B_E1 = 0;
	localparam int B_RX_ESF = 1;
	localparam int B_RX_LC = 2;
	localparam int B_FSRC = 0;
	localparam int B_FCORR = 0;
	localparam int B_LCSEL = 1;
	localparam int B_ESF = 2;
	localparam int B_RESYNC = 0;
	localparam int B_FRAME_LOSS = 0;
	localparam int B_LOS = 0;
	localparam int B_RA = 5;
	localparam int ST1_LOF = 0;
	localparam int ST1_SYNC = 1;
	localparam int ST1_LOS = 2;
	localparam int ST2_RMF = 0;
	localparam int ST2_TMF = 1;
	localparam int ST4_CAPT = 0;
	// Last frame index of each format
	localparam logic [6:0] LAST_D4 = 7'h0b;
	localparam logic [6:0] LAST_ESF = 7'h17;
	localparam logic [6:0] LAST_LC = 7'h47;
	localparam logic [6:0] LAST_E1 = 7'h0f;
	// Fixed patterns
	localparam logic [10:0] FS_PAT = 11'h71c;
	localparam logic [5:0] SEQ_PAT = 6'h34;
	localparam logic [6:0] FAS_PAT = 7'h1b;
	localparam logic [7:0] MASK_FAS = 8'h7f;
	localparam logic [7:0] MASK_NFAS = 8'h40;
	localparam logic [6:0] E1_EBIT_IDX = 7'h0c;
	// Loop-carrier data positions, counted in even frames
	localparam logic [5:0] LC_C_FIRST = 6'h0b;
	localparam logic [5:0] LC_C_LAST = 6'h15;
	localparam logic [5:0] LC_M_FIRST = 6'h19;
	localparam logic [5:0] LC_S_LAST = 6'h21;
	localparam logic [5:0] LC_M_BASE = 6'h0e;
	// Receive thresholds: sync runs in checked frames, loss of signal in received frames
	localparam logic [2:0] GOOD_LO = 3'h2;
	localparam logic [2:0] GOOD_HI = 3'h3;
	localparam logic [2:0] ERR_LO = 3'h2;
	localparam logic [2:0] ERR_HI = 3'h4;
	localparam logic [2:0] ERR_E1 = 3'h3;
	localparam logic [7:0] LOS_LO = 8'h20;
	localparam logic [7:0] LOS_HI = 8'h10;
	localparam logic HRESP_OKAY = 1'h0;
	typedef enum logic {LCF_SEARCH, LCF_SYNC} lcf_rx_state_t;
endpackage

// >>> lcf_sat_cnt.sv
`timescale 1ns/1ps
// ----------------------------------------
// Saturating counter with clear
// ----------------------------------------
module lcf_sat_cnt #(
	parameter int W = 8
) (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic clr_in,
	input wire logic inc_in,
	output logic [W-1:0] cnt_out
);
	// Clear wins; stops at all ones so it never wraps
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_out <= '0;
		end else if (clr_in) begin
			cnt_out <= '0;
		end else if (inc_in && !(&cnt_out)) begin
			cnt_out <= cnt_out + 1'h1;
		end
	end
endmodule

// >>> lcf_oh_gen.sv
`timescale 1ns/1ps
// ----------------------------------------
// Overhead pattern for one frame index
// ----------------------------------------
module lcf_oh_gen
	import lcf_pkg::*;
(
	input wire logic esf_in,
	input wire logic [6:0] idx_in,
	input wire logic [19:0] lc_bits_in,
	input wire logic ra_in,
	input wire logic [4:0] datalink_in,
	input wire logic [3:0] crc_in,
	input wire logic [1:0] ebit_in,
	output logic t1_bit_out,
	output logic chk_out,
	output logic lc_hit_out,
	output logic [4:0] lc_pos_out,
	output logic [7:0] e1_byte_out,
	output logic [7:0] e1_mask_out
);
	logic [5:0] k; // Even-frame ordinal
	logic b1; // E1 bit 1 of odd frames

	// T1 framing bit; chk marks fixed-pattern positions
	always_comb begin
		k = idx_in[6:1];
		t1_bit_out = 1'h1;
		chk_out = 1'h0;
		lc_hit_out = 1'h0;
		lc_pos_out = 5'h00;
		if (esf_in) begin
			// Pattern bit on every fourth frame
			if (idx_in[1:0] == 2'h3) begin
				t1_bit_out = SEQ_PAT[idx_in[4:2]];
				chk_out = 1'h1;
			end
		end else if (!idx_in[0]) begin
			t1_bit_out = ~idx_in[1];
			chk_out = 1'h1;
		end else if (k < LC_C_FIRST) begin
			t1_bit_out = FS_PAT[k[3:0]];
			chk_out = 1'h1;
		end else if (k <= LC_C_LAST) begin
			lc_hit_out = 1'h1;
			lc_pos_out = 5'(k - LC_C_FIRST);
			t1_bit_out = lc_bits_in[lc_pos_out];
		end else if (k < LC_M_FIRST) begin
			t1_bit_out = k[0];
			chk_out = 1'h1;
		end else if (k <= LC_S_LAST) begin
			lc_hit_out = 1'h1;
			lc_pos_out = 5'(k - LC_M_BASE);
			t1_bit_out = lc_bits_in[lc_pos_out];
		end else begin
			t1_bit_out = ~k[0];
			chk_out = 1'h1;
		end
	end

	// E1 time slot zero byte, bit 1 in the msb
	always_comb begin
		b1 = 1'h0;
		if (!idx_in[0]) begin
			e1_byte_out = {crc_in[idx_in[2:1]], FAS_PAT};
			e1_mask_out = MASK_FAS;
		end else begin
			if (idx_in < E1_EBIT_IDX) begin
				b1 = SEQ_PAT[idx_in[3:1]];
			end else begin
				b1 = ebit_in[idx_in[1]];
			end
			// bit 2 high, alarm, datalink bits
			e1_byte_out = {b1, 1'h1, ra_in, datalink_in};
			e1_mask_out = MASK_NFAS;
		end
	end
endmodule

// >>> lcf_framer.sv
`timescale 1ns/1ps
// ----------------------------------------
// ----------------------------------------
module lcf_framer
	import lcf_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	input wire logic tx_frame_stb_in, // Start of each transmit frame
	input wire logic tx_fbit_in, // F-bit from backplane
	input wire logic [3:0] tx_crc_in, // CRC-4 remainder
	input wire logic [1:0] tx_ebit_in, // Far-end CRC error bits
	output logic tx_fbit_out,
	output logic [7:0] tx_ts0_out,
	output logic [6:0] tx_frame_out,
	output logic tx_mf_start_out,
	input wire logic rx_frame_stb_in, // Start of each receive frame
	input wire logic rx_fbit_in,
	input wire logic [7:0] rx_ts0_in,
	output logic rx_in_sync_out,
	output logic rx_los_out,
	output logic rx_event_out
);
	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	logic acc_ok; // Address phase taken
	logic wr_pend_q; // Write data phase
	logic rd_pend_q; // Read data phase
	logic hit_q; // Address inside the map
	logic [8:0] idx_q; // Register index
	logic [7:0] rd_byte; // Read mux
	logic wr_en; // Write strobe
	logic [7:0] wd; // Written byte

	assign acc_ok = hsel_in & hready_in & htrans_in[1];
	assign wr_en = wr_pend_q & hit_q;
	assign wd = hwdata_in[7:0];

	// Capture address phase
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			wr_pend_q <= 1'h0;
			rd_pend_q <= 1'h0;
			hit_q <= 1'h0;
			idx_q <= 9'h000;
		end else begin
			wr_pend_q <= acc_ok & hwrite_in;
			rd_pend_q <= acc_ok & ~hwrite_in;
			if (acc_ok) begin
				idx_q <= haddr_in[10:2];
				hit_q <= (haddr_in[31:11] == 21'h000000);
			end
		end
	end

	// One wait state on reads so a write just ahead is seen
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			hreadyout_out <= 1'h1;
			hrdata_out <= 32'h00000000;
			hresp_out <= HRESP_OKAY;
		end else begin
			hreadyout_out <= !(acc_ok && !hwrite_in);
			hresp_out <= HRESP_OKAY;
			if (rd_pend_q) begin
				hrdata_out <= {24'h000000, hit_q ? rd_byte : 8'h00};
			end
		end
	end

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	logic [7:0] tx_master_q, tx_ctl1_q, tx_ctl2_q, tx_ctl3_q;
	logic [7:0] tx_lc_a_q, tx_lc_b_q, tx_lc_c_q, tx_e1_oh_q;
	logic [7:0] rx_master_q, rx_ctl1_q, t1_crit_q, e1_los_q;
	logic [7:0] rx_irq_mask_one_q, rx_irq_mask_two_q, rx_irq_mask_four_q;

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			tx_master_q <= 8'h00;
			tx_ctl1_q <= 8'h00;
			tx_ctl2_q <= 8'h00;
			tx_ctl3_q <= 8'h00;
			tx_lc_a_q <= 8'h00;
			tx_lc_b_q <= 8'h00;
			tx_lc_c_q <= 8'h00;
			tx_e1_oh_q <= 8'h00;
			rx_master_q <= 8'h00;
			rx_ctl1_q <= 8'h00;
			t1_crit_q <= 8'h00;
			e1_los_q <= 8'h00;
			rx_irq_mask_one_q <= 8'h00;
			rx_irq_mask_two_q <= 8'h00;
			rx_irq_mask_four_q <= 8'h00;
		end else if (wr_en) begin
			case (idx_q)
				IDX_TX_MASTER: tx_master_q <= wd;
				IDX_TX_CTL1: tx_ctl1_q <= wd;
				IDX_TX_CTL2: tx_ctl2_q <= wd;
				IDX_TX_CTL3: tx_ctl3_q <= wd;
				IDX_TX_LC_A: tx_lc_a_q <= wd;
				IDX_TX_LC_B: tx_lc_b_q <= wd;
				IDX_TX_LC_C: tx_lc_c_q <= wd;
				IDX_TX_E1_OH: tx_e1_oh_q <= wd;
				IDX_RX_MASTER: rx_master_q <= wd;
				IDX_RX_CTL1: rx_ctl1_q <= wd;
				IDX_T1_CRIT: t1_crit_q <= wd;
				IDX_E1_LOS: e1_los_q <= wd;
				IDX_RX_IRQ_MASK_ONE: rx_irq_mask_one_q <= wd;
				IDX_RX_IRQ_MASK_TWO: rx_irq_mask_two_q <= wd;
				IDX_RX_IRQ_MASK_FOUR: rx_irq_mask_four_q <= wd;
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// Transmit framer
	// ----------------------------------------
	logic tx_e1, tx_esf, tx_lc, tx_corr;
	logic [6:0] tx_idx_q; // Zero-based frame in superframe
	logic [6:0] tx_last;
	logic tx_bit, tx_chk;
	logic [7:0] tx_byte;

	assign tx_e1 = tx_master_q[B_E1];
	assign tx_esf = tx_ctl3_q[B_ESF];
	assign tx_lc = tx_ctl2_q[B_LCSEL];
	assign tx_corr = tx_ctl2_q[B_FCORR];

	// last frame index of the chosen format
	always_comb begin
		if (tx_e1) begin
			tx_last = LAST_E1;
		end else if (tx_esf) begin
			tx_last = LAST_ESF;
		end else if (tx_lc) begin
			tx_last = LAST_LC;
		end else begin
			tx_last = LAST_D4;
		end
	end

	lcf_oh_gen u_tx_gen (
		.esf_in(tx_esf),
		.idx_in(tx_idx_q),
		.lc_bits_in({tx_lc_c_q[3:0], tx_lc_b_q, tx_lc_a_q}),
		.ra_in(tx_e1_oh_q[B_RA]),
		.datalink_in(tx_e1_oh_q[4:0]),
		.crc_in(tx_crc_in),
		.ebit_in(tx_ebit_in),
		.t1_bit_out(tx_bit),
		.chk_out(tx_chk),
		.lc_hit_out(),
		.lc_pos_out(),
		.e1_byte_out(tx_byte),
		.e1_mask_out()
	);

	// Overhead registered at each frame start
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			tx_idx_q <= 7'h00;
			tx_fbit_out <= 1'h0;
			tx_ts0_out <= 8'h00;
			tx_frame_out <= 7'h00;
			tx_mf_start_out <= 1'h0;
		end else if (tx_frame_stb_in) begin
			tx_fbit_out <= tx_ctl1_q[B_FSRC] ? tx_fbit_in : tx_bit ^ (tx_corr & tx_chk);
			tx_ts0_out <= tx_byte ^ {7'h00, tx_corr & ~tx_idx_q[0]};
			tx_frame_out <= tx_idx_q;
			tx_mf_start_out <= (tx_idx_q == 7'h00);
			// wrap after last frame; a shortened format also wraps
			tx_idx_q <= (tx_idx_q >= tx_last) ? 7'h00 : tx_idx_q + 7'h01;
		end else begin
			tx_mf_start_out <= 1'h0;
		end
	end

	// ----------------------------------------
	// Receive framer
	// ----------------------------------------
	lcf_rx_state_t state_q;
	logic rx_e1;
	logic [6:0] rx_idx_q, rx_last, rx_next;
	logic [2:0] run_q; // Good or bad run length
	logic [2:0] need, lim;
	logic rx_bit, rx_chk, lc_hit;
	logic [4:0] lc_pos;
	logic [7:0] rx_exp, rx_mask;
	logic chk, match, gain_ev, lof_ev, rmf_ev;

	assign rx_e1 = rx_master_q[B_E1];

	// receive format on its own settings
	always_comb begin
		if (rx_e1) begin
			rx_last = LAST_E1;
		end else if (rx_master_q[B_RX_ESF]) begin
			rx_last = LAST_ESF;
		end else if (rx_master_q[B_RX_LC]) begin
			rx_last = LAST_LC;
		end else begin
			rx_last = LAST_D4;
		end
	end

	lcf_oh_gen u_rx_gen (
		.esf_in(rx_master_q[B_RX_ESF]),
		.idx_in(rx_idx_q),
		.lc_bits_in(20'h00000),
		.ra_in(1'h0),
		.datalink_in(5'h00),
		.crc_in(4'h0),
		.ebit_in(2'h0),
		.t1_bit_out(rx_bit),
		.chk_out(rx_chk),
		.lc_hit_out(lc_hit),
		.lc_pos_out(lc_pos),
		.e1_byte_out(rx_exp),
		.e1_mask_out(rx_mask)
	);

	assign rx_next = (rx_idx_q >= rx_last) ? 7'h00 : rx_idx_q + 7'h01;
	// Only fixed-pattern positions are judged
	assign chk = rx_e1 | rx_chk;
	assign match = rx_e1 ? (((rx_ts0_in ^ rx_exp) & rx_mask) == 8'h00) : (rx_fbit_in == rx_bit);
	assign need = rx_ctl1_q[B_RESYNC] ? GOOD_HI : GOOD_LO;
	// Errors before out of frame; E1 uses its own limit
	assign lim = rx_e1 ? ERR_E1 : (t1_crit_q[B_FRAME_LOSS] ? ERR_HI : ERR_LO);
	assign gain_ev = rx_frame_stb_in & (state_q == LCF_SEARCH) & chk & match
		& (run_q + 3'h1 >= need);
	assign lof_ev = rx_frame_stb_in & (state_q == LCF_SYNC) & chk & ~match
		& (run_q + 3'h1 >= lim);
	assign rmf_ev = rx_frame_stb_in & (state_q == LCF_SYNC) & (rx_idx_q == rx_last);

	// hunt by holding phase on a miss, then sync
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_q <= LCF_SEARCH;
			run_q <= 3'h0;
			rx_idx_q <= 7'h00;
		end else if (rx_frame_stb_in) begin
			case (state_q)
				LCF_SEARCH: begin
					if (chk && !match) begin
						run_q <= 3'h0;
					end else begin
						rx_idx_q <= rx_next;
						if (gain_ev) begin
							state_q <= LCF_SYNC;
							run_q <= 3'h0;
						end else if (chk) begin
							run_q <= run_q + 3'h1;
						end
					end
				end
				LCF_SYNC: begin
					rx_idx_q <= rx_next;
					if (lof_ev) begin
						state_q <= LCF_SEARCH;
						run_q <= 3'h0;
					end else if (chk && !match) begin
						run_q <= run_q + 3'h1;
					end else if (chk) begin
						run_q <= 3'h0;
					end
				end
				default: state_q <= LCF_SEARCH;
			endcase
		end
	end

	// ----------------------------------------
	// Counters, captures and status
	// ----------------------------------------
	logic [15:0] oos_cnt;
	logic [7:0] zero_cnt;
	logic los_d;
	logic [19:0] rx_lc_q;
	logic [7:0] e1_align_q, e1_nonalign_q;
	logic [7:0] rx_latched_status_one_q, rx_latched_status_two_q, rx_latched_status_four_q;
	logic cap_ev;

	lcf_sat_cnt #(.W(16)) u_oos_cnt (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.clr_in(1'h0),
		.inc_in(rx_frame_stb_in & (state_q == LCF_SEARCH)),
		.cnt_out(oos_cnt)
	);

	lcf_sat_cnt #(.W(8)) u_zero_cnt (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.clr_in(rx_frame_stb_in & (rx_ts0_in != 8'h00)),
		.inc_in(rx_frame_stb_in),
		.cnt_out(zero_cnt)
	);

	assign los_d = rx_e1 & (zero_cnt >= (e1_los_q[B_LOS] ? LOS_HI : LOS_LO));
	assign cap_ev = rx_frame_stb_in & (state_q == LCF_SYNC);

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			rx_lc_q <= 20'h00000;
			e1_align_q <= 8'h00;
			e1_nonalign_q <= 8'h00;
		end else if (cap_ev && rx_e1) begin
			if (rx_idx_q[0]) begin
				e1_nonalign_q <= rx_ts0_in;
			end else begin
				e1_align_q <= rx_ts0_in;
			end
		end else if (cap_ev && rx_master_q[B_RX_LC] && !rx_master_q[B_RX_ESF] && lc_hit) begin
			rx_lc_q[lc_pos] <= rx_fbit_in;
		end
	end

	// sticky bits, write one clears, new event wins
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			rx_latched_status_one_q <= 8'h00;
			rx_latched_status_two_q <= 8'h00;
			rx_latched_status_four_q <= 8'h00;
		end else begin
			rx_latched_status_one_q <= (rx_latched_status_one_q & ~((wr_en && idx_q == IDX_RX_LATCHED_STATUS_ONE) ? wd : 8'h00))
				| {5'h00, los_d & ~rx_los_out, gain_ev, lof_ev};
			rx_latched_status_two_q <= (rx_latched_status_two_q & ~((wr_en && idx_q == IDX_RX_LATCHED_STATUS_TWO) ? wd : 8'h00))
				| {6'h00, tx_frame_stb_in & (tx_idx_q == 7'h00), rmf_ev};
			rx_latched_status_four_q <= (rx_latched_status_four_q & ~((wr_en && idx_q == IDX_RX_LATCHED_STATUS_FOUR) ? wd : 8'h00))
				| {7'h00, cap_ev & rx_e1};
		end
	end

	// Live status pins and masked event summary
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			rx_in_sync_out <= 1'h0;
			rx_los_out <= 1'h0;
			rx_event_out <= 1'h0;
		end else begin
			rx_in_sync_out <= (state_q == LCF_SYNC);
			rx_los_out <= los_d;
			rx_event_out <= |((rx_latched_status_one_q & rx_irq_mask_one_q) | (rx_latched_status_two_q & rx_irq_mask_two_q) | (rx_latched_status_four_q & rx_irq_mask_four_q));
		end
	end

	// shared addresses decoded by receive mode
	always_comb begin
		case (idx_q)
			IDX_TX_MASTER: rd_byte = tx_master_q;
			IDX_TX_CTL1: rd_byte = tx_ctl1_q;
			IDX_TX_CTL2: rd_byte = tx_ctl2_q;
			IDX_TX_CTL3: rd_byte = tx_ctl3_q;
			IDX_TX_LC_A: rd_byte = tx_lc_a_q;
			IDX_TX_LC_B: rd_byte = tx_lc_b_q;
			IDX_TX_LC_C: rd_byte = tx_lc_c_q;
			IDX_TX_E1_OH: rd_byte = tx_e1_oh_q;
			IDX_RX_MASTER: rd_byte = rx_master_q;
			IDX_RX_CTL1: rd_byte = rx_ctl1_q;
			IDX_T1_CRIT: rd_byte = t1_crit_q;
			IDX_E1_LOS: rd_byte = e1_los_q;
			IDX_RX_IRQ_MASK_ONE: rd_byte = rx_irq_mask_one_q;
			IDX_RX_IRQ_MASK_TWO: rd_byte = rx_irq_mask_two_q;
			IDX_RX_IRQ_MASK_FOUR: rd_byte = rx_irq_mask_four_q;
			IDX_RX_LATCHED_STATUS_ONE: rd_byte = rx_latched_status_one_q;
			IDX_RX_LATCHED_STATUS_TWO: rd_byte = rx_latched_status_two_q;
			IDX_RX_LATCHED_STATUS_FOUR: rd_byte = rx_latched_status_four_q;
			IDX_OOS_A: rd_byte = oos_cnt[7:0];
			IDX_OOS_B: rd_byte = oos_cnt[15:8];
			IDX_RX_LC_A: rd_byte = rx_e1 ? e1_align_q : rx_lc_q[7:0];
			IDX_RX_LC_B: rd_byte = rx_e1 ? e1_nonalign_q : rx_lc_q[15:8];
			IDX_RX_LC_C: rd_byte = rx_e1 ? 8'h00 : {4'h0, rx_lc_q[19:16]};
			default: rd_byte = 8'h00;
		endcase
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);

	a_read_wait: assert property (acc_ok && !hwrite_in |=> !hreadyout_out ##1 hreadyout_out)
		else $error("read wait state wrong");
	a_ft_alternate: assert property (tx_frame_stb_in && !tx_e1 && !tx_esf && !tx_corr
		&& !tx_ctl1_q[B_FSRC] && !tx_idx_q[0] |=> tx_fbit_out == ~$past(tx_idx_q[1]))
		else $error("terminal framing bit wrong");
	a_lc_spoiler: assert property (tx_frame_stb_in && tx_lc && !tx_e1 && !tx_esf
		&& !tx_corr && !tx_ctl1_q[B_FSRC] && tx_idx_q == 7'h2f |=> tx_fbit_out)
		else $error("spoiler bit wrong");
	a_fas_word: assert property (tx_frame_stb_in && !tx_idx_q[0] && !tx_corr
		|=> tx_ts0_out[6:0] == FAS_PAT)
		else $error("alignment word wrong");
	a_nfas_fields: assert property (tx_frame_stb_in && tx_idx_q[0]
		|=> tx_ts0_out[6] && tx_ts0_out[4:0] == $past(tx_e1_oh_q[4:0]))
		else $error("non-alignment byte wrong");
	a_mfa_first: assert property (tx_frame_stb_in && tx_idx_q == 7'h01 |=> !tx_ts0_out[7])
		else $error("multiframe sequence wrong");
	a_fbit_source: assert property (tx_frame_stb_in && tx_ctl1_q[B_FSRC]
		|=> tx_fbit_out == $past(tx_fbit_in))
		else $error("F-bit source wrong");
	a_tx_wrap: assert property (tx_frame_stb_in && tx_idx_q >= tx_last |=> tx_idx_q == 7'h00
		##0 tx_mf_start_out == 1'h0 ##1 1'h1)
		else $error("transmit frame wrap wrong");
	a_oos_count: assert property (rx_frame_stb_in && state_q == LCF_SEARCH && !(&oos_cnt)
		|=> oos_cnt == $past(oos_cnt) + 16'h0001)
		else $error("out-of-sync count wrong");
	a_lof_latch: assert property (lof_ev |=> rx_latched_status_one_q[ST1_LOF] && state_q == LCF_SEARCH)
		else $error("loss of alignment not latched");
	a_mask_gate: assert property (rx_latched_status_one_q == 8'h00 && rx_latched_status_two_q == 8'h00 && rx_latched_status_four_q == 8'h00
		|=> !rx_event_out)
		else $error("event without status");

	c_sync_gain: cover property (gain_ev);
	c_sync_loss: cover property (lof_ev);
	c_tx_mf: cover property (tx_mf_start_out);
	c_read: cover property (rd_pend_q && hit_q);
endmodule

// >>> lcf_line_model.sv
`timescale 1ns/1ps
// --------
// Line-side frame source
// --------
module lcf_line_model (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic en_in,
	input wire logic err_in, // Breaks both overhead words, a good frame resets the error run
	output logic stb_out,
	output logic [7:0] ts0_out
);
	logic [1:0] div_q; // Frame spacing
	logic [3:0] k_q; // Multiframe position
	// One frame every four clocks
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			div_q <= 2'h0;
			stb_out <= 1'b0;
		end else begin
			div_q <= div_q + 2'h1;
			stb_out <= en_in && div_q == 2'h3;
		end
	end
	// Slot-0 byte; toggles between frames so stale data never looks valid
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			k_q <= 4'h0;
			ts0_out <= 8'h00;
		end else if (en_in && div_q == 2'h3) begin
			k_q <= k_q + 4'h1;
			ts0_out <= k_q[0] ? 8'h40 ^ {1'b0, err_in, 6'h00} : {1'b0, 7'h1b ^ {6'h00, err_in}};
		end else begin
			ts0_out <= ~ts0_out;
		end
	end
endmodule

// >>> lcf_framer_bench.sv
`timescale 1ns/1ps
module lcf_framer_bench
	import lcf_pkg::*;
;
	// --------
	// Stimulus and wiring
	// --------
	logic sys_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic hsel = 1'b0, hwrite = 1'b0, hready, hresp, en = 1'b0, rxon = 1'b0, err = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [1:0] htrans = 2'h0;
	logic tx_fbit = 1'b0, stb, fbit_o, mf, sync, los, evt;
	logic [3:0] crc = 4'ha; // CRC bits 1..4 = 0,1,0,1
	logic [1:0] ebit = 2'h2; // E1=0, E2=1
	logic [7:0] ts0, ts0_o, q, t;
	logic [6:0] fr_o;
	logic [19:0] v = 20'ha9ec5; // Loop-carrier data loaded below
	int n_mismatch = 0, comparisons = 0, n;
	logic [8:0] rw[14] = '{IDX_T1_CRIT, IDX_RX_CTL1, IDX_E1_LOS, IDX_RX_IRQ_MASK_ONE, IDX_RX_IRQ_MASK_TWO,
		IDX_RX_IRQ_MASK_FOUR, IDX_TX_LC_A, IDX_TX_LC_B, IDX_TX_LC_C, IDX_TX_CTL1, IDX_TX_CTL2,
		IDX_TX_CTL3, IDX_TX_MASTER, IDX_RX_MASTER};
	logic [7:0] mm[4] = '{8'h00, 8'h00, 8'h00, 8'h01}, c2[4] = '{8'h00, 8'h00, 8'h02, 8'h00};
	logic [7:0] c3[4] = '{8'h00, 8'h04, 8'h00, 8'h00}, pr[4] = '{8'h0c, 8'h18, 8'h48, 8'h10};
	lcf_framer u_dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .hsel_in(hsel),
		.haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
		.hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
		.hresp_out(hresp), .tx_frame_stb_in(stb), .tx_fbit_in(tx_fbit), .tx_crc_in(crc),
		.tx_ebit_in(ebit), .tx_fbit_out(fbit_o), .tx_ts0_out(ts0_o), .tx_frame_out(fr_o),
		.tx_mf_start_out(mf), .rx_frame_stb_in(stb & rxon), .rx_fbit_in(ts0[7]),
		.rx_ts0_in(ts0), .rx_in_sync_out(sync), .rx_los_out(los), .rx_event_out(evt));
	lcf_line_model u_line (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .en_in(en),
		.err_in(err), .stb_out(stb), .ts0_out(ts0));
	// Clock at 40 MHz
	initial begin
		forever #12.5 sys_clk_in = ~sys_clk_in;
	end
	// --------
	// Tasks
	// --------
	task report_and_stop;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task chk(input string s, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", s, exp, seen);
		end
	endtask
	// One single word transfer; waits on hready only
	task bus(input logic w, input logic [8:0] i, input logic [7:0] d);
		@(posedge sys_clk_in);
		hsel <= 1'b1;
		hwrite <= w;
		htrans <= 2'h2;
		haddr <= {21'h0, i, 2'h0};
		do @(posedge sys_clk_in); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge sys_clk_in); while (hready !== 1'b1);
		q = hrdata[7:0];
		chk("response", hresp, 16'h0);
	endtask
	// Next frame strobe, outputs settled
	task nf;
		do @(posedge sys_clk_in); while (stb !== 1'b1);
		@(negedge sys_clk_in);
	endtask
	task mfs;
		do nf(); while (mf !== 1'b1);
	endtask
	// Expected F-bit of loop-carrier frame n (1..72)
	function automatic logic fexp(int n);
		int m;
		m = n / 2;
		if (n % 2) return ((n - 1) / 2) % 2 == 0;
		if (m <= 11) return (11'h71c >> (m - 1)) & 1;
		if (m <= 22) return v[m - 12];
		if (m == 24 || m == 35) return 1'b1;
		if (m == 23 || m == 25 || m == 36) return 1'b0;
		return v[m - 15];
	endfunction
	// Hang guard
	initial begin
		repeat (20000) @(posedge sys_clk_in);
		n_mismatch++;
		report_and_stop();
	end
	// --------
	// Sequence
	// --------
	initial begin
		repeat (12) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		foreach (rw[i]) begin
			bus(1'b0, rw[i], 8'h00);
			chk("reset value", q, 16'h0);
			bus(1'b1, rw[i], 8'ha5);
			bus(1'b0, rw[i], 8'h00);
			chk("readback", q, 16'ha5);
			bus(1'b1, rw[i], 8'h00);
		end
		bus(1'b1, IDX_OOS_A, 8'hff);
		bus(1'b0, IDX_OOS_A, 8'h00);
		chk("ro count", q, 16'h0);
		bus(1'b1, 9'h1ff, 8'hff);
		bus(1'b0, 9'h1ff, 8'h00);
		chk("unmapped", q, 16'h0);
		en <= 1'b1;
		bus(1'b1, IDX_TX_CTL1, 8'h01);
		mfs();
		chk("fbit source", fbit_o, 16'h0);
		bus(1'b1, IDX_TX_CTL1, 8'h00);
		bus(1'b1, IDX_TX_CTL2, 8'h01);
		mfs();
		chk("fbit corrupt", fbit_o, 16'h0);
		for (int j = 0; j < 4; j++) begin
			bus(1'b1, IDX_TX_MASTER, mm[j]);
			bus(1'b1, IDX_TX_CTL2, c2[j]);
			bus(1'b1, IDX_TX_CTL3, c3[j]);
			mfs();
			n = 0;
			do begin
				nf();
				n++;
			end while (mf !== 1'b1);
			chk("frames per super", n[15:0], {8'h0, pr[j]});
		end
		// Loop-carrier content over all 72 frames
		bus(1'b1, IDX_TX_MASTER, 8'h00);
		bus(1'b1, IDX_TX_CTL2, 8'h02);
		bus(1'b1, IDX_TX_LC_A, v[7:0]);
		bus(1'b1, IDX_TX_LC_B, v[15:8]);
		bus(1'b1, IDX_TX_LC_C, {4'h0, v[19:16]});
		mfs();
		for (int f = 1; f <= 72; f++) begin
			chk("lc fbit", fbit_o, {15'h0, fexp(f)});
			chk("frame index", fr_o, f[15:0] - 16'h1);
			nf();
		end
		// E1 slot-0 content, alarm set, datalink = 01011
		bus(1'b1, IDX_TX_MASTER, 8'h01);
		bus(1'b1, IDX_TX_E1_OH, 8'h2b);
		mfs();
		for (int k = 0; k < 16; k++) begin
			t = k == 13 ? ebit[0] : k == 15 ? ebit[1] : 6'h34 >> ((k - 1) / 2) & 1;
			t = k % 2 ? {t[0], 7'h6b} : {crc[(k / 2) % 4], 7'h1b};
			chk("e1 slot0", ts0_o, {8'h0, t});
			nf();
		end
		// Receive E1: align, capture, then lose alignment
		bus(1'b1, IDX_RX_MASTER, 8'h01);
		bus(1'b1, IDX_RX_IRQ_MASK_ONE, 8'h03);
		rxon <= 1'b1;
		do @(posedge sys_clk_in); while (sync !== 1'b1);
		bus(1'b0, IDX_RX_LATCHED_STATUS_ONE, 8'h00);
		chk("sync gained", q, 16'h2);
		bus(1'b1, IDX_RX_LATCHED_STATUS_ONE, 8'h02);
		bus(1'b0, IDX_RX_LATCHED_STATUS_ONE, 8'h00);
		chk("status cleared", q, 16'h0);
		chk("event idle", evt, 16'h0);
		bus(1'b0, IDX_RX_LC_A, 8'h00);
		chk("align byte", q, 16'h1b);
		bus(1'b0, IDX_RX_LC_B, 8'h00);
		chk("nonalign byte", q, 16'h40);
		err <= 1'b1;
		do @(posedge sys_clk_in); while (sync !== 1'b0);
		repeat (40) nf();
		bus(1'b0, IDX_RX_LATCHED_STATUS_ONE, 8'h00);
		chk("loss flagged", q & 8'h01, 16'h1);
		chk("event raised", evt, 16'h1);
		chk("no loss of signal", los, 16'h0);
		bus(1'b0, IDX_OOS_A, 8'h00);
		t = q;
		bus(1'b0, IDX_OOS_B, 8'h00);
		chk("out of sync count", (t | q) != 8'h00, 16'h1);
		report_and_stop();
	end
endmodule
